// File: src/crs_defines.svh
/*
 crs_defines.svh: offsets, field positions, reset values and timing counts
 for the core reset and interrupt sequencer.
 Assumes inclusion by bare name from the sequencer sources.
*/
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// register byte offsets on the axi4-lite port
`define CRS_OFF_STATUS    8'h00
`define CRS_OFF_EXT_CTRL  8'h04
`define CRS_OFF_EXT_FLAG  8'h08
`define CRS_OFF_SHARED    8'h0c
`define CRS_OFF_PER_EN    8'h10
`define CRS_OFF_PER_FLAG  8'h14
`define CRS_OFF_PER_DATA  8'h18
`define CRS_OFF_STACK     8'h1c

// status register fields
`define CRS_ST_MASK       0
`define CRS_ST_WAIT       1
`define CRS_ST_HALT       2
`define CRS_ST_STAB       3
`define CRS_ST_RESET      4

// reset values and vectors
`define CRS_SP_HIGH       8'h01
`define CRS_SP_RESET      8'hff
`define CRS_TMR_INIT      16'hfffc
`define CRS_VEC_RESET     16'hfffe
`define CRS_VEC_TRAP      16'hfffc
`define CRS_VEC_EXT0      16'hfff0
`define CRS_VEC_PER0      16'hffea

// cpu clock cycle counts
`define CRS_RST_CYCLES    13'h1000
`define CRS_STAB_CYCLES   13'h1000

`define CRS_RESP_OKAY     2'h0
`define CRS_RESP_SLVERR   2'h2

`endif

// File: src/crs_pkg.sv
/*
 crs_pkg: sequencer state type.
 Assumes nothing of its surroundings.
*/
package crs_pkg;
   typedef enum logic [3:0] {
      CRS_RESET    = 4'h0,
      CRS_PIN_WAIT = 4'h1,
      CRS_STAB     = 4'h2,
      CRS_BOOT     = 4'h3,
      CRS_RUN      = 4'h4,
      CRS_WAIT     = 4'h5,
      CRS_HALT     = 4'h6,
      CRS_PUSH     = 4'h7,
      CRS_VECTOR   = 4'h8,
      CRS_POP      = 4'h9,
      CRS_POP_END  = 4'ha
   } crs_state_t;
endpackage

// File: src/crs_sync.sv
/*
 crs_sync: two flip-flop synchroniser, one bit per lane.
 Assumes inputs asynchronous to aclk; lanes are independent levels.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   // meta feeds q only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         q    <= '0;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// File: src/crs_delay_timer.sv
/*
 crs_delay_timer: loadable down counter; expire pulses in the last cycle.
 Assumes start is a one-cycle request from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_delay_timer #(
   parameter int              CW   = 13,
   parameter logic [CW-1:0]   INIT = '1
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   input  wire logic          start,
   input  wire logic [CW-1:0] load,
   output logic               expire
);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;

   // a load of n gives n cycles ending with expire
   assign next_cnt = start ? load : ((cnt != '0) ? cnt - CW'(1) : cnt);
   assign expire   = (cnt == CW'(1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= INIT;
      end else if (ce) begin
         cnt <= next_cnt;
      end
   end
endmodule
`default_nettype wire

// File: src/crs_sequencer.sv
/*
 crs_sequencer: reset stretching, oscillator recovery, interrupt arbitration,
 context push, vector load and return for an 8-bit core.
 Assumes core strobes on aclk, a stack ram read in the same cycle,
 pins and power-on pulse asynchronous, axi4-lite master on aclk.
*/
// Our own choices: the register offsets and register access over AXI4-Lite.
// Function
// - reset held exactly 4096 cycles, mirrored on pin
// - stay in reset while pin held low
// - 4096 cycle recovery after power-on or halt
// - open-drain reset pin; external low resets
// - reset clears timer, loads fffc, inputs ports
// - reset loads stack 01ff, vector fffe, masks
// - wait or halt entry clears mask bit
// - reset clears latches, watchdog, port, peripheral registers
// - oscillator and timer clock stopped in reset, halt
// - finish instruction, push context, mask, load vector
// - return pops context, mask restored from stacked cc
// - maskable served only with mask clear, latched
// - fixed priority among simultaneous requests
// - trap served regardless of mask
// - any wakes wait; selected sources wake halt
// - edge latched, cleared on entering service
// - shared source ors participating pins
// - low participating pin blocks shared request
// - peripheral request needs enable and clear mask
// - flag cleared by zero write or sequence
// - clearing sequence drops a pending request
// - push low pc byte first, decrement after
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.svh"
module crs_sequencer #(
   parameter int          NEXT        = 4,
   parameter int          NSH         = 4,
   parameter int          NPER        = 4,
   parameter logic [3:0]  HALT_WAKE   = 4'h0,
   parameter logic [12:0] RST_CYCLES  = `CRS_RST_CYCLES,
   parameter logic [12:0] STAB_CYCLES = `CRS_STAB_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [2:0]  ded_pin,
   input  wire logic [3:0]  shared_pin,
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe_n,
   input  wire logic        por_in,
   input  wire logic        wdg_reset,
   input  wire logic [3:0]  per_req,
   input  wire logic        core_instr_done,
   input  wire logic        core_trap,
   input  wire logic        core_wfi,
   input  wire logic        core_halt,
   input  wire logic        core_return,
   input  wire logic        core_set_mask,
   input  wire logic        core_clr_mask,
   input  wire logic [15:0] core_pc,
   input  wire logic [7:0]  core_x,
   input  wire logic [7:0]  core_a,
   input  wire logic [7:0]  core_cc,
   input  wire logic [7:0]  stk_rdata,
   output logic             stk_we,
   output logic             stk_re,
   output logic [15:0]      stk_addr,
   output logic [7:0]       stk_wdata,
   output logic             core_reset,
   output logic             core_run,
   output logic             mask_i,
   output logic             vec_load,
   output logic [15:0]      vec_addr,
   output logic             restore_valid,
   output logic [15:0]      restore_pc,
   output logic [7:0]       restore_x,
   output logic [7:0]       restore_a,
   output logic [7:0]       restore_cc,
   output logic             osc_en,
   output logic             tmr_clk_en,
   output logic             periph_reset,
   output logic [15:0]      tmr_init_value
);
   localparam int W = NSH + NEXT + 1;

   crs_pkg::crs_state_t state;
   crs_pkg::crs_state_t next_state;

   logic [W-1:0]    sync_q;
   logic [NEXT-1:0] ext_en;
   logic [NEXT-1:0] ext_rise;
   logic [NEXT-1:0] ext_flag;
   logic [NEXT-1:0] lvl_prev;
   logic [NSH-1:0]  sh_en;
   logic [NPER-1:0] per_en;
   logic [NPER-1:0] per_flag;
   logic [NPER-1:0] per_armed;
   logic [7:0]      sp_lo;
   logic            por_seen;
   logic            halt_exit;
   logic [39:0]     ctx;
   logic [39:0]     pop_sh;
   logic [2:0]      step;
   logic [4:0]      svc_src;
   logic            svc_trap;
   logic            aw_hold;
   logic            w_hold;
   logic [7:0]      aw_q;
   logic [31:0]     w_q;
   logic            ws_q;

   function automatic logic [4:0] pick(input logic [NEXT-1:0] e, input logic [NPER-1:0] p);
      logic [4:0] r;
      r = 5'h00;
      for (int k = NPER - 1; k >= 0; k--) if (p[k]) r = 5'(NEXT + k);
      for (int k = 0; k < NEXT; k++) if (e[k]) r = 5'(k);
      return r;
   endfunction

   function automatic logic [15:0] vec_of(input logic [4:0] s);
      logic [15:0] off;
      off = {10'h000, s, 1'b0};
      if (s < 5'(NEXT)) return `CRS_VEC_EXT0 + off;
      return `CRS_VEC_PER0 - off + 16'(2 * NEXT);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `CRS_OFF_STACK);
   endfunction

   // por, pin, then interrupt pins, all through two flops
   crs_sync #(.W(W)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       ({por_in, reset_pin_in, ded_pin, shared_pin}),
      .q       (sync_q)
   );

   wire              por_s = sync_q[W-1];
   wire              pin_s = sync_q[W-2];
   wire [NEXT-2:0]   ded_s = sync_q[NSH +: NEXT-1];
   wire [NSH-1:0]    sh_s  = sync_q[NSH-1:0];

   // shared source: or of participating pins, any low one blocks rising
   wire              sh_or  = |(sh_s & sh_en);
   wire              sh_low = |(~sh_s & sh_en);
   wire [NEXT-1:0]   lvl    = {ded_s, sh_or};
   wire [NEXT-1:0]   blk    = {{(NEXT-1){1'b0}}, sh_low};
   wire [NEXT-1:0]   ext_hit = (ext_rise & ~lvl_prev & lvl & ~blk)
                             | (~ext_rise & lvl_prev & ~lvl);

   wire [NEXT-1:0]   ext_pend  = ext_flag & ext_en;
   wire [NPER-1:0]   per_pend  = per_flag & per_en;
   wire              mask_pend = |ext_pend | |per_pend;
   wire              halt_wake = |ext_pend | |(per_pend & HALT_WAKE);
   wire [4:0]        sel       = pick(ext_pend, per_pend);

   wire in_rst   = (state == crs_pkg::CRS_RESET);
   wire rst_any  = por_s | wdg_reset | (~pin_s & (state != crs_pkg::CRS_PIN_WAIT));
   wire take     = (state == crs_pkg::CRS_RUN) & core_instr_done
                 & (core_trap | (mask_pend & ~mask_i));
   wire go_svc   = (next_state == crs_pkg::CRS_PUSH) & (state != crs_pkg::CRS_PUSH);
   wire lp_entry = (state == crs_pkg::CRS_RUN)
                 & ((next_state == crs_pkg::CRS_WAIT) | (next_state == crs_pkg::CRS_HALT));
   wire tmr_exp;
   wire tmr_start = (next_state != state)
                  & ((next_state == crs_pkg::CRS_RESET) | (next_state == crs_pkg::CRS_STAB));
   wire [12:0] tmr_load = (next_state == crs_pkg::CRS_RESET) ? RST_CYCLES : STAB_CYCLES;

   crs_delay_timer #(.CW(13), .INIT(RST_CYCLES)) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .start   (tmr_start),
      .load    (tmr_load),
      .expire  (tmr_exp)
   );

   always_comb begin
      next_state = state;
      unique case (state)
         crs_pkg::CRS_RESET:    if (tmr_exp) next_state = crs_pkg::CRS_PIN_WAIT;
         crs_pkg::CRS_PIN_WAIT: if (pin_s) begin
            next_state = por_seen ? crs_pkg::CRS_STAB : crs_pkg::CRS_BOOT;
         end
         crs_pkg::CRS_STAB: if (tmr_exp) begin
            if (!halt_exit) next_state = crs_pkg::CRS_BOOT;
            else if (mask_pend) next_state = crs_pkg::CRS_PUSH;
            else next_state = crs_pkg::CRS_RUN;
         end
         crs_pkg::CRS_BOOT:     next_state = crs_pkg::CRS_RUN;
         crs_pkg::CRS_RUN: begin
            if (take) next_state = crs_pkg::CRS_PUSH;
            else if (core_return) next_state = crs_pkg::CRS_POP;
            else if (core_wfi) next_state = crs_pkg::CRS_WAIT;
            else if (core_halt) next_state = crs_pkg::CRS_HALT;
         end
         crs_pkg::CRS_WAIT:     if (mask_pend) next_state = crs_pkg::CRS_PUSH;
         crs_pkg::CRS_HALT:     if (halt_wake) next_state = crs_pkg::CRS_STAB;
         crs_pkg::CRS_PUSH:     if (step == 3'h4) next_state = crs_pkg::CRS_VECTOR;
         crs_pkg::CRS_VECTOR:   next_state = crs_pkg::CRS_RUN;
         crs_pkg::CRS_POP:      if (step == 3'h4) next_state = crs_pkg::CRS_POP_END;
         crs_pkg::CRS_POP_END:  next_state = crs_pkg::CRS_RUN;
         default:               next_state = crs_pkg::CRS_RESET;
      endcase
      if (!in_rst && rst_any) next_state = crs_pkg::CRS_RESET;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= crs_pkg::CRS_RESET;
         por_seen  <= 1'b1;
         halt_exit <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         if (next_state == crs_pkg::CRS_RESET && !in_rst) por_seen <= por_s;
         if (state == crs_pkg::CRS_HALT) halt_exit <= 1'b1;
         else if (state != crs_pkg::CRS_STAB) halt_exit <= 1'b0;
      end
   end

   // mask bit: reset sets, service sets, low-power entry clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_i <= 1'b1;
      end else if (ce) begin
         if (in_rst) mask_i <= 1'b1;
         else if (state == crs_pkg::CRS_VECTOR) mask_i <= 1'b1;
         else if (lp_entry) mask_i <= 1'b0;
         else if (state == crs_pkg::CRS_POP_END) mask_i <= pop_sh[11];
         else if (core_set_mask) mask_i <= 1'b1;
         else if (core_clr_mask) mask_i <= 1'b0;
      end
   end

   // context: pcl first at sp, pointer decremented after each byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_lo     <= `CRS_SP_RESET;
         step      <= 3'h0;
         ctx       <= '0;
         pop_sh    <= '0;
         svc_src   <= 5'h00;
         svc_trap  <= 1'b0;
         stk_we    <= 1'b0;
         stk_re    <= 1'b0;
         stk_addr  <= 16'h0000;
         stk_wdata <= 8'h00;
      end else if (ce) begin
         stk_we <= (state == crs_pkg::CRS_PUSH);
         stk_re <= (state == crs_pkg::CRS_POP);
         step   <= (state == next_state) ? step + 3'h1 : 3'h0;
         if (in_rst) sp_lo <= `CRS_SP_RESET;
         if (go_svc) begin
            svc_src  <= sel;
            svc_trap <= take & core_trap;
            ctx      <= {core_cc[7:4], mask_i, core_cc[2:0], core_a, core_x, core_pc};
         end
         if (state == crs_pkg::CRS_PUSH) begin
            stk_addr  <= {`CRS_SP_HIGH, sp_lo};
            stk_wdata <= ctx[7:0];
            ctx       <= {8'h00, ctx[39:8]};
            sp_lo     <= sp_lo - 8'h01;
         end
         if (state == crs_pkg::CRS_POP) begin
            stk_addr <= {`CRS_SP_HIGH, sp_lo + 8'h01};
            sp_lo    <= sp_lo + 8'h01;
         end
         // cc lands first and sits one byte up until pcl arrives
         if (stk_re) pop_sh <= {stk_rdata, pop_sh[39:8]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vec_load      <= 1'b0;
         vec_addr      <= 16'h0000;
         restore_valid <= 1'b0;
      end else if (ce) begin
         vec_load      <= (state == crs_pkg::CRS_BOOT) | (state == crs_pkg::CRS_VECTOR);
         restore_valid <= (state == crs_pkg::CRS_POP_END);
         if (state == crs_pkg::CRS_BOOT) vec_addr <= `CRS_VEC_RESET;
         else if (state == crs_pkg::CRS_VECTOR) begin
            vec_addr <= svc_trap ? `CRS_VEC_TRAP : vec_of(svc_src);
         end
      end
   end

   assign restore_pc     = {pop_sh[31:24], pop_sh[39:32]};
   assign restore_x      = pop_sh[23:16];
   assign restore_a      = pop_sh[15:8];
   assign restore_cc     = pop_sh[7:0];
   assign core_reset     = in_rst | (state == crs_pkg::CRS_PIN_WAIT);
   assign core_run       = (state == crs_pkg::CRS_RUN);
   assign reset_pin_out  = 1'b0;
   assign reset_pin_oe_n = ~in_rst;
   assign osc_en         = ~(in_rst | (state == crs_pkg::CRS_HALT));
   assign tmr_clk_en     = ~(in_rst | (state == crs_pkg::CRS_HALT));
   assign periph_reset   = in_rst;
   assign tmr_init_value = `CRS_TMR_INIT;

   // axi4-lite slave: one write and one read at a time
   assign s_axi_awready = ce & ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ce & ~w_hold & ~s_axi_bvalid;
   assign s_axi_arready = ce & ~s_axi_rvalid;

   wire        wr_go   = aw_hold & w_hold & ~s_axi_bvalid;
   wire        wr_ok   = wr_go & ws_q;
   wire        rd_go   = s_axi_arvalid & s_axi_arready;
   wire        wr_ext  = wr_ok & (aw_q == `CRS_OFF_EXT_CTRL);
   wire        wr_eflg = wr_ok & (aw_q == `CRS_OFF_EXT_FLAG);
   wire        wr_sh   = wr_ok & (aw_q == `CRS_OFF_SHARED);
   wire        wr_pen  = wr_ok & (aw_q == `CRS_OFF_PER_EN);
   wire        wr_pflg = wr_ok & (aw_q == `CRS_OFF_PER_FLAG);
   wire        acc_pst = wr_pflg | (rd_go & (s_axi_araddr == `CRS_OFF_PER_FLAG));
   wire        acc_pdt = (wr_ok & (aw_q == `CRS_OFF_PER_DATA))
                       | (rd_go & (s_axi_araddr == `CRS_OFF_PER_DATA));
   wire [NEXT-1:0] clr_svc = ((state == crs_pkg::CRS_VECTOR) && !svc_trap && svc_src < 5'(NEXT))
                           ? NEXT'(1) << svc_src : '0;
   wire [NEXT-1:0] clr_esw = wr_eflg ? ~w_q[NEXT-1:0] : '0;
   wire [NPER-1:0] clr_psw = wr_pflg ? ~w_q[NPER-1:0] : '0;
   wire [NPER-1:0] clr_seq = acc_pdt ? per_armed : '0;

   wire [31:0] status_w = {27'h0, in_rst, (state == crs_pkg::CRS_STAB),
                           (state == crs_pkg::CRS_HALT), (state == crs_pkg::CRS_WAIT), mask_i};
   wire [31:0] rd_val =
      (s_axi_araddr == `CRS_OFF_STATUS)   ? status_w :
      (s_axi_araddr == `CRS_OFF_EXT_CTRL) ? {{(32-2*NEXT){1'b0}}, ext_rise, ext_en} :
      (s_axi_araddr == `CRS_OFF_EXT_FLAG) ? {{(32-NEXT){1'b0}}, ext_flag} :
      (s_axi_araddr == `CRS_OFF_SHARED)   ? {{(32-NSH){1'b0}}, sh_en} :
      (s_axi_araddr == `CRS_OFF_PER_EN)   ? {{(32-NPER){1'b0}}, per_en} :
      (s_axi_araddr == `CRS_OFF_PER_FLAG) ? {{(32-NPER){1'b0}}, per_flag} :
      (s_axi_araddr == `CRS_OFF_STACK)    ? {16'h0000, `CRS_SP_HIGH, sp_lo} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         aw_q         <= 8'h00;
         w_q          <= 32'h0000_0000;
         ws_q         <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CRS_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `CRS_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_q    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            ws_q         <= ws_q & mapped(aw_q);
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_q) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // request latches: a new edge or request wins over any clear except reset
   always_ff @(posedge aclk) begin
      if (!aresetn || (ce && in_rst)) begin
         ext_en    <= '0;
         ext_rise  <= '0;
         ext_flag  <= '0;
         sh_en     <= '0;
         per_en    <= '0;
         per_flag  <= '0;
         per_armed <= '0;
         lvl_prev  <= '0;
      end else if (ce) begin
         lvl_prev <= lvl;
         ext_flag <= (ext_flag & ~clr_esw & ~clr_svc) | ext_hit;
         per_flag <= (per_flag & ~clr_psw & ~clr_seq) | per_req;
         if (acc_pst) per_armed <= per_flag;
         else if (acc_pdt) per_armed <= '0;
         if (wr_ext) begin
            ext_en   <= w_q[NEXT-1:0];
            ext_rise <= w_q[2*NEXT-1:NEXT];
         end
         if (wr_sh) sh_en <= w_q[NSH-1:0];
         if (wr_pen) per_en <= w_q[NPER-1:0];
      end
   end
endmodule
`default_nettype wire

// File: bench/crs_seq_properties.sv
/* crs_seq_properties: timing checks on the sequencer ports.
   assumes binding to crs_sequencer, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module crs_seq_properties #(
   parameter logic [12:0] RST_CYCLES = 13'h1000
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        reset_pin_oe_n,
   input wire logic        core_reset,
   input wire logic        core_run,
   input wire logic        osc_en,
   input wire logic        tmr_clk_en,
   input wire logic        periph_reset,
   input wire logic        mask_i,
   input wire logic        vec_load,
   input wire logic        stk_we,
   input wire logic        restore_valid,
   input wire logic        core_instr_done,
   input wire logic        core_trap,
   input wire logic        core_wfi,
   input wire logic        core_return,
   input wire logic [15:0] tmr_init_value,
   input wire logic [15:0] vec_addr
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // counts low cycles of the pin drive; cleared by reset
   logic [12:0] lo;
   always_ff @(posedge aclk) lo <= (!aresetn || reset_pin_oe_n) ? 13'h0 : lo + 13'h1;
   property p_rst_len; reset_pin_oe_n && $past(!reset_pin_oe_n) |-> lo == RST_CYCLES; endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset drive length wrong");
   property p_pin_core; !reset_pin_oe_n |-> core_reset && !core_run; endproperty
   a_pin_core: assert property (p_pin_core) else $error("core not in reset");
   property p_stop; !reset_pin_oe_n |-> !osc_en && !tmr_clk_en && periph_reset; endproperty
   a_stop: assert property (p_stop) else $error("clocks not stopped in reset");
   property p_tmr; tmr_init_value == 16'hfffc; endproperty
   a_tmr: assert property (p_tmr) else $error("timer init value wrong");
   property p_vec_mask; vec_load |-> mask_i; endproperty
   a_vec_mask: assert property (p_vec_mask) else $error("mask clear at vector");
   property p_wfi; core_run && core_wfi |=> !mask_i; endproperty
   a_wfi: assert property (p_wfi) else $error("mask not cleared on wait");
   property p_push; vec_load && vec_addr != 16'hfffe |-> $past(stk_we) && $past(stk_we, 5); endproperty
   a_push: assert property (p_push) else $error("vector without push");
   property p_trap; core_run && core_instr_done && core_trap |-> ##7 vec_load && vec_addr == 16'hfffc;
   endproperty
   a_trap: assert property (p_trap) else $error("trap vector missing");
   property p_ret; core_run && core_return |-> ##7 restore_valid; endproperty
   a_ret: assert property (p_ret) else $error("return restore missing");
   c_ext: cover property (vec_load && vec_addr == 16'hfff2);
   c_ret: cover property (restore_valid);
   c_rst: cover property (reset_pin_oe_n && $past(!reset_pin_oe_n));
endmodule
bind crs_sequencer crs_seq_properties #(.RST_CYCLES(RST_CYCLES)) chk_u (.*);
`default_nettype wire

// File: bench/crs_stack_model.sv
/* crs_stack_model: stack ram beside the core, combinational read.
   assumes byte strobes from the sequencer on aclk. */
`timescale 1ns/1ps
`default_nettype none
module crs_stack_model (
   input  wire logic        aclk,
   input  wire logic        stk_we,
   input  wire logic        stk_re,
   input  wire logic [15:0] stk_addr,
   input  wire logic [7:0]  stk_wdata,
   output var  logic [7:0]  stk_rdata
);
   logic [7:0] mem [0:511];
   // idle shows a fixed pattern, so stale data never looks valid
   assign stk_rdata = stk_re ? mem[stk_addr[8:0]] : 8'h5a;
   always @(posedge aclk) begin
      if (stk_we) mem[stk_addr[8:0]] <= stk_wdata;
   end
endmodule
`default_nettype wire

// File: bench/tb.sv
/* tb: register, interrupt and reset sequences for crs_sequencer.
   assumes short reset and recovery counts of 16. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic aclk = 0, aresetn = 0, ce = 1, por_in = 0, wdg_reset = 0, ext_n = 1;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, stk_rdata, stk_wdata, restore_x, restore_a, restore_cc;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, shared_pin = 4'hf, per_req = 0;
   logic [2:0] ded_pin = 3'h7;
   logic [6:0] cs = 0;
   logic [39:0] ctx = 40'h12345678a1;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] stk_addr, vec_addr, restore_pc, tmr_init_value, core_pc;
   logic [7:0] core_x, core_a, core_cc;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_out;
   logic reset_pin_oe_n, stk_we, stk_re, core_reset, core_run, mask_i, vec_load, restore_valid;
   logic osc_en, tmr_clk_en, periph_reset, reset_pin_in, core_instr_done, core_trap, core_wfi;
   logic core_halt, core_return, core_set_mask, core_clr_mask;
   int n_fail = 0, compares = 0, cyc = 0;
   // pull-up wire: device pulls low, outside agent pulls low
   assign reset_pin_in = ext_n & reset_pin_oe_n;
   assign {core_pc, core_x, core_a, core_cc} = ctx;
   assign {core_clr_mask, core_set_mask, core_return, core_halt, core_wfi, core_trap,
           core_instr_done} = cs;
   crs_sequencer #(.RST_CYCLES(13'h10), .STAB_CYCLES(13'h10)) dut_u (.*);
   crs_stack_model stk_u (.*);
   always #20 aclk = ~aclk;
   task final_report;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         final_report;
      end
   end
   task chk(input logic [39:0] g, input logic [39:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task clk(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task pu(input logic [6:0] v);
      @(posedge aclk) cs <= v;
      @(posedge aclk) cs <= 7'h0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] p;
      p = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (p != 2'h0) begin
         @(posedge aclk);
         if (p[1] && s_axi_awready === 1'b1) begin s_axi_awvalid <= 0; p[1] = 0; end
         if (p[0] && s_axi_wready === 1'b1) begin s_axi_wvalid <= 0; p[0] = 0; end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(s_axi_bresp, 2'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk({s_axi_rresp, s_axi_rdata}, {(a > 8'h1c) ? 2'h2 : 2'h0, e});
   endtask
   task wv(input logic [15:0] e);
      for (int i = 0; i < 60 && vec_load !== 1'b1; i++) @(posedge aclk);
      chk({vec_load, vec_addr}, {1'b1, e});
   endtask
   task wrun;
      for (int i = 0; i < 200 && core_run !== 1'b1; i++) @(posedge aclk);
      chk(core_run, 1'b1);
   endtask
   initial begin
      clk(4);
      aresetn <= 1;
      wrun;
      rd(8'h00, 32'h1);
      rd(8'h1c, 32'h1ff);
      rd(8'h20, 32'h0);
      wr(8'h04, 32'h2);
      ded_pin <= 3'h6;
      clk(6);
      rd(8'h08, 32'h2);
      pu(7'h40);
      pu(7'h01);
      wv(16'hfff2);
      rd(8'h08, 32'h0);
      rd(8'h1c, 32'h1fa);
      pu(7'h10);
      clk(8);
      chk({restore_pc, restore_x, restore_a, restore_cc}, ctx);
      rd(8'h00, 32'h0);
      pu(7'h20);
      pu(7'h03);
      wv(16'hfffc);
      pu(7'h10);
      clk(8);
      pu(7'h04);
      clk(2);
      rd(8'h00, 32'h2);
      wr(8'h10, 32'h1);
      per_req <= 4'h1;
      clk(1);
      per_req <= 4'h0;
      wv(16'hffea);
      pu(7'h10);
      clk(8);
      per_req <= 4'h2;
      clk(1);
      per_req <= 4'h0;
      rd(8'h14, 32'h3);
      wr(8'h14, 32'h2);
      rd(8'h14, 32'h2);
      rd(8'h18, 32'h0);
      rd(8'h14, 32'h0);
      ext_n <= 0;
      clk(25);
      chk(core_reset, 1'b1);
      ext_n <= 1;
      wrun;
      rd(8'h10, 32'h0);
      wdg_reset <= 1;
      clk(1);
      wdg_reset <= 0;
      clk(3);
      chk(core_reset, 1'b1);
      wrun;
      rd(8'h00, 32'h1);
      final_report;
   end
endmodule
`default_nettype wire
